//--- asu_pkg.sv
`default_nettype none
package asu_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CTL1 = 4'h0;
  localparam logic [3:0] ADDR_CTL2 = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam logic [3:0] ADDR_DATA = 4'hC;
  // control one
  localparam int C1_WORD9 = 0;
  localparam int C1_TX9   = 1;
  localparam int C1_RX9   = 2;
  // status
  localparam int ST_TX_EMPTY_FLAG = 7;
  localparam int ST_TC   = 6;
  localparam int ST_RX_FULL_FLAG = 5;
  localparam int ST_IDLE = 4;
  localparam int ST_OVR  = 3;
  localparam int ST_NF   = 2;
  localparam int ST_FE   = 1;
  // frame timing, in bit periods and 16x samples
  localparam logic [3:0] LEN_8   = 4'hA;
  localparam logic [3:0] LEN_9   = 4'hB;
  localparam logic [3:0] LEN_ONE = 4'h1;
  localparam logic [4:0] SMP_A   = 5'h08;
  localparam logic [4:0] SMP_B   = 5'h09;
  localparam logic [4:0] SMP_C   = 5'h0A;
  localparam logic [4:0] SMP_END = 5'h10;
  localparam logic [7:0] IDLE_8  = 8'hA0;
  localparam logic [7:0] IDLE_9  = 8'hB0;
  localparam logic [10:0] FRM_ONES = 11'h7FF;
  localparam logic [10:0] FRM_ZERO = 11'h000;
  // control two, as carried around the core
  typedef struct packed {
    logic tx_empty_irq_enable;
    logic tx_complete_irq_enable;
    logic rx_irq_enable;
    logic idle_irq_enable;
    logic te;
    logic re;
    logic rsv;
    logic send_break_ctrl;
  } asu_ctl_type;
  localparam asu_ctl_type CTL_RST = 8'h00;
  typedef enum logic [2:0] {
    RX_HUNT  = 3'b001,
    RX_START = 3'b010,
    RX_DATA  = 3'b100
  } asu_rx_state_type;
endpackage : asu_pkg
`default_nettype wire

//--- asu_tx_shift.sv
`default_nettype none
module asu_tx_shift
  import asu_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        tick_in,
  input  wire logic        load_in,
  input  wire logic [10:0] frame_in,
  input  wire logic [3:0]  len_in,
  output logic             busy_out,
  output logic             end_out,
  output logic             txd_out
);
  logic [10:0] sh_q;
  logic [3:0]  cnt_q;
  assign end_out = tick_in && busy_out && (cnt_q == 4'h0);
  // load only on a tick: first bit goes out at once, no lost period
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      sh_q     <= FRM_ONES;
      cnt_q    <= 4'h0;
      busy_out <= 1'b0;
      txd_out  <= 1'b1;
    end else if (tick_in && load_in) begin
      txd_out  <= frame_in[0];
      sh_q     <= {1'b1, frame_in[10:1]};
      cnt_q    <= len_in - LEN_ONE;
      busy_out <= 1'b1;
    end else if (tick_in && busy_out && cnt_q != 4'h0) begin
      txd_out <= sh_q[0];
      sh_q    <= {1'b1, sh_q[10:1]};
      cnt_q   <= cnt_q - LEN_ONE;
    end else if (!busy_out || end_out) begin
      busy_out <= 1'b0;
      txd_out  <= 1'b1;
    end
  end
endmodule : asu_tx_shift
`default_nettype wire

//--- asu_rx_vote.sv
`default_nettype none
module asu_rx_vote
  import asu_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       tick_in,
  input  wire logic [4:0] smp_in,
  input  wire logic       rxd_in,
  output logic            bit_out,
  output logic            noise_out
);
  logic s8_q;
  logic s9_q;
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      s8_q      <= 1'b1;
      s9_q      <= 1'b1;
      bit_out   <= 1'b1;
      noise_out <= 1'b0;
    end else if (tick_in) begin
      if (smp_in == SMP_A) s8_q <= rxd_in;
      if (smp_in == SMP_B) s9_q <= rxd_in;
      if (smp_in == SMP_C) begin
        bit_out   <= (s8_q & s9_q) | (s8_q & rxd_in) | (s9_q & rxd_in);
        noise_out <= !((s8_q == s9_q) && (s9_q == rxd_in));
      end
    end
  end
endmodule : asu_rx_vote
`default_nettype wire

//--- asu_core.sv
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`default_nettype none
module asu_core
  import asu_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        tx_tick_in,
  input  wire logic        rx_tick_in,
  input  wire logic        serial_rx_line_in,
  input  wire logic        cpu_irq_mask_in,
  output logic             serial_tx_line_out,
  output logic             irq_out
);
  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  asu_ctl_type ctl_q;
  logic        word9_q;
  logic        tx_ninth_bit_q;
  logic        rx_ninth_bit_q;
  logic [7:0]  tx_buf_q;
  logic [7:0]  rx_buf_q;
  logic        tx_empty_flag_q, tc_q, rx_full_flag_q, idle_q, ovr_q, nf_q, fe_q;
  logic        seen_q;
  logic        acc;
  logic        wr_acc;
  logic        rd_acc;
  logic        lane0;
  logic [7:0]  status;
  logic [7:0]  rdval;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction : hit

  // one wait state: request sampled, answer stands next cycle
  assign acc    = (avs_read_in || avs_write_in) && !avs_waitrequest_out;
  assign wr_acc = acc && avs_write_in;
  assign rd_acc = acc && avs_read_in;
  assign lane0  = avs_byteenable_in[0];
  assign status = {tx_empty_flag_q, tc_q, rx_full_flag_q, idle_q, ovr_q, nf_q, fe_q, 1'b0};

  always_comb begin
    rdval = 8'h00;
    if (hit(avs_address_in, ADDR_CTL1))
      rdval = {5'h00, rx_ninth_bit_q, tx_ninth_bit_q, word9_q};
    else if (hit(avs_address_in, ADDR_CTL2))
      rdval = ctl_q;
    else if (hit(avs_address_in, ADDR_STAT))
      rdval = status;
    else if (hit(avs_address_in, ADDR_DATA))
      rdval = rx_buf_q;
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
    end else if (acc) begin
      avs_waitrequest_out <= 1'b1;
    end else if (avs_read_in || avs_write_in) begin
      avs_waitrequest_out <= 1'b0;
      avs_readdata_out    <= {24'h00_0000, rdval};
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ctl_q          <= CTL_RST;
      word9_q        <= 1'b0;
      tx_ninth_bit_q <= 1'b0;
    end else if (wr_acc && lane0) begin
      if (hit(avs_address_in, ADDR_CTL2))
        ctl_q <= avs_writedata_in[7:0];
      if (hit(avs_address_in, ADDR_CTL1)) begin
        word9_q        <= avs_writedata_in[C1_WORD9];
        tx_ninth_bit_q <= avs_writedata_in[C1_TX9];
      end
    end
  end

  // status read arms the clear; any data access consumes it
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in)
      seen_q <= 1'b0;
    else if (rd_acc && hit(avs_address_in, ADDR_STAT))
      seen_q <= 1'b1;
    else if (acc && hit(avs_address_in, ADDR_DATA))
      seen_q <= 1'b0;
  end

  logic dwr_clr;
  logic drd_clr;
  assign dwr_clr = wr_acc && hit(avs_address_in, ADDR_DATA) && seen_q;
  assign drd_clr = rd_acc && hit(avs_address_in, ADDR_DATA) && seen_q;

  // ---------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------
  logic        tx_busy, tx_end, tx_free, tx_load, txd;
  logic        buf_full_q, pend_idle_q, brk_tail_q, te_prev_q;
  logic        kind_dat_q, kind_brk_q;
  logic        dwr;
  logic        direct;
  logic [10:0] frame;
  logic [3:0]  flen;
  logic [3:0]  len;

  assign dwr     = wr_acc && lane0 && hit(avs_address_in, ADDR_DATA);
  assign direct  = !tx_busy && !buf_full_q && ctl_q.te;
  assign len     = word9_q ? LEN_9 : LEN_8;
  assign tx_free = tx_tick_in && (!tx_busy || tx_end);
  assign tx_load = tx_free && ctl_q.te && (pend_idle_q || ctl_q.send_break_ctrl
                   || brk_tail_q || buf_full_q);

  always_comb begin
    frame = FRM_ONES;
    flen  = len;
    if (pend_idle_q) begin
      frame = FRM_ONES;
    end else if (ctl_q.send_break_ctrl) begin
      frame = FRM_ZERO;
    end else if (brk_tail_q) begin
      frame = FRM_ONES;
      flen  = LEN_ONE;
    end else if (word9_q) begin
      frame = {1'b1, tx_ninth_bit_q, tx_buf_q, 1'b0};
    end else begin
      frame = {2'b11, tx_buf_q, 1'b0};
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      te_prev_q   <= 1'b0;
      pend_idle_q <= 1'b0;
      brk_tail_q  <= 1'b0;
      kind_dat_q  <= 1'b0;
      kind_brk_q  <= 1'b0;
    end else begin
      te_prev_q <= ctl_q.te;
      if (ctl_q.te && !te_prev_q)
        pend_idle_q <= 1'b1;
      else if (tx_load && pend_idle_q)
        pend_idle_q <= 1'b0;
      if (tx_load) begin
        kind_brk_q <= !pend_idle_q && ctl_q.send_break_ctrl;
        kind_dat_q <= !pend_idle_q && !ctl_q.send_break_ctrl && !brk_tail_q;
        brk_tail_q <= !pend_idle_q && ctl_q.send_break_ctrl;
      end else if (tx_end) begin
        kind_brk_q <= 1'b0;
        kind_dat_q <= 1'b0;
      end
    end
  end

  logic ld_data;
  assign ld_data = tx_load && !pend_idle_q && !ctl_q.send_break_ctrl && !brk_tail_q;

  // set wins over the clear sequence in the same cycle
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      buf_full_q <= 1'b0;
      tx_buf_q   <= 8'h00;
      tx_empty_flag_q     <= 1'b1;
      tc_q       <= 1'b1;
    end else begin
      if (ctl_q.te && !te_prev_q || !ctl_q.te && te_prev_q) begin
        buf_full_q <= 1'b0;
        tx_empty_flag_q     <= 1'b1;
      end else begin
        // a write in the load cycle must not be lost: it refills
        if (dwr) begin
          tx_buf_q   <= avs_writedata_in[7:0];
          buf_full_q <= 1'b1;
          if (seen_q && !direct)
            tx_empty_flag_q <= 1'b0;
        end
        if (ld_data && !dwr)
          buf_full_q <= 1'b0;
        if (ld_data)
          tx_empty_flag_q <= 1'b1;
      end
      if (tx_end && (kind_dat_q || kind_brk_q) && !ld_data)
        tc_q <= 1'b1;
      else if (dwr_clr)
        tc_q <= 1'b0;
    end
  end

  asu_tx_shift u_tx (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .tick_in    (tx_tick_in),
    .load_in    (tx_load),
    .frame_in   (frame),
    .len_in     (flen),
    .busy_out   (tx_busy),
    .end_out    (tx_end),
    .txd_out    (txd)
  );
  assign serial_tx_line_out = txd;

  // ---------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------
  asu_rx_state_type rx_st_q;
  logic       rxd_q, rxd_prev_q, vbit, vnoise;
  logic [4:0] smp_q;
  logic [3:0] bits_q;
  logic [8:0] rsh_q;
  logic       nacc_q, hid_nf_q, idle_arm_q;
  logic [7:0] icnt_q;
  logic       smp_end, chr_done, stop_bad, false_start, idle_hit;

  assign smp_end     = rx_tick_in && smp_q == SMP_END;
  assign false_start = rx_st_q == RX_START && smp_end && vbit;
  assign chr_done    = rx_st_q == RX_DATA && smp_end && bits_q == 4'h0;
  assign stop_bad    = !vbit;
  assign idle_hit    = idle_arm_q && rx_st_q == RX_HUNT
                       && icnt_q == (word9_q ? IDLE_9 : IDLE_8);

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rxd_q      <= 1'b1;
      rxd_prev_q <= 1'b1;
    end else if (rx_tick_in) begin
      rxd_q      <= serial_rx_line_in;
      rxd_prev_q <= rxd_q;
    end
  end

  asu_rx_vote u_vote (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .tick_in    (rx_tick_in),
    .smp_in     (smp_q),
    .rxd_in     (rxd_q),
    .bit_out    (vbit),
    .noise_out  (vnoise)
  );

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || !ctl_q.re) begin
      rx_st_q <= RX_HUNT;
      smp_q   <= 5'h00;
      bits_q  <= 4'h0;
      rsh_q   <= 9'h000;
      nacc_q  <= 1'b0;
    end else if (rx_tick_in) begin
      unique case (rx_st_q)
        RX_HUNT: begin
          if (rxd_prev_q && !rxd_q) begin
            rx_st_q <= RX_START;
            smp_q   <= 5'h02;
            nacc_q  <= 1'b0;
          end
        end
        RX_START: begin
          smp_q <= smp_end ? 5'h01 : smp_q + 5'h01;
          if (false_start)
            rx_st_q <= RX_HUNT;
          else if (smp_end) begin
            rx_st_q <= RX_DATA;
            bits_q  <= len - LEN_ONE - LEN_ONE;
            nacc_q  <= vnoise;
          end
        end
        RX_DATA: begin
          smp_q <= smp_end ? 5'h01 : smp_q + 5'h01;
          if (smp_end) begin
            nacc_q <= nacc_q | vnoise;
            if (bits_q == 4'h0)
              rx_st_q <= RX_HUNT;
            else begin
              bits_q <= bits_q - 4'h1;
              rsh_q  <= word9_q ? {vbit, rsh_q[8:1]}
                                : {1'b0, vbit, rsh_q[7:1]};
            end
          end
        end
      endcase
    end
  end

  // idle: a frame of ones counted after enable or a character
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || !ctl_q.re) begin
      icnt_q     <= 8'h00;
      idle_arm_q <= 1'b1;
    end else begin
      if (chr_done)
        idle_arm_q <= 1'b1;
      else if (idle_hit)
        idle_arm_q <= 1'b0;
      if (rx_st_q != RX_HUNT || !rxd_q || idle_hit)
        icnt_q <= 8'h00;
      else if (rx_tick_in)
        icnt_q <= icnt_q + 8'h01;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rx_full_flag_q <= 1'b0;
      ovr_q  <= 1'b0;
      nf_q   <= 1'b0;
      fe_q   <= 1'b0;
      idle_q <= 1'b0;
      hid_nf_q       <= 1'b0;
      rx_buf_q       <= 8'h00;
      rx_ninth_bit_q <= 1'b0;
    end else begin
      if (false_start)
        hid_nf_q <= 1'b1;
      if (chr_done && rx_full_flag_q) begin
        ovr_q <= 1'b1;
      end else if (chr_done) begin
        rx_full_flag_q         <= 1'b1;
        rx_buf_q       <= rsh_q[7:0];
        rx_ninth_bit_q <= rsh_q[8];
        nf_q           <= nacc_q | hid_nf_q;
        fe_q           <= stop_bad;
        hid_nf_q       <= 1'b0;
      end else if (drd_clr) begin
        rx_full_flag_q <= 1'b0;
        ovr_q  <= 1'b0;
        nf_q   <= 1'b0;
        fe_q   <= 1'b0;
      end
      if (idle_hit)
        idle_q <= 1'b1;
      else if (drd_clr)
        idle_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // interrupt request
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in)
      irq_out <= 1'b0;
    else
      irq_out <= !cpu_irq_mask_in && ((ctl_q.tx_empty_irq_enable && tx_empty_flag_q)
                 || (ctl_q.tx_complete_irq_enable && tc_q)
                 || (ctl_q.rx_irq_enable && (rx_full_flag_q || ovr_q))
                 || (ctl_q.idle_irq_enable && idle_q));
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_status_read;
    rd_acc && hit(avs_address_in, ADDR_STAT);
  endsequence
  sequence s_data_read;
    rd_acc && hit(avs_address_in, ADDR_DATA);
  endsequence

  chk_line_idle_high: assert property (
    !tx_busy && $past(!tx_busy) |-> serial_tx_line_out)
    else $error("line not high while transmitter idle");
  chk_break_zero: assert property (
    tx_tick_in && tx_load && ctl_q.send_break_ctrl && !pend_idle_q |=> !serial_tx_line_out)
    else $error("break frame did not drive zero");
  chk_tx_empty_flag_clear: assert property (
    $fell(tx_empty_flag_q) |-> $past(dwr && seen_q))
    else $error("tx empty cleared without status then write");
  chk_direct_keep: assert property (
    dwr && direct && !(ctl_q.te ^ te_prev_q) |=> tx_empty_flag_q && buf_full_q)
    else $error("direct write cleared tx empty");
  chk_seen_arm: assert property (
    s_status_read |=> seen_q)
    else $error("status read did not arm the clear");
  chk_rx_full_flag_clear: assert property (
    (s_data_read and (seen_q && !chr_done)) |=> !rx_full_flag_q)
    else $error("rx full not cleared by status then read");
  chk_overrun_keep: assert property (
    chr_done && rx_full_flag_q |=> ovr_q && $stable(rx_buf_q))
    else $error("overrun did not keep buffer");
  chk_false_start: assert property (
    false_start |=> rx_st_q == RX_HUNT && hid_nf_q && $stable(rx_full_flag_q))
    else $error("false start not discarded");
  chk_tx_irq: assert property (
    (ctl_q.tx_empty_irq_enable && tx_empty_flag_q && !cpu_irq_mask_in)[*2] |-> irq_out)
    else $error("tx empty interrupt missing");
  chk_tc_set: assert property (
    tx_end && kind_dat_q && !ld_data |=> tc_q)
    else $error("tx complete not set at frame end");
endmodule : asu_core
`default_nettype wire

//--- asu_far_end.sv
`default_nettype none
module asu_far_end (
  input  wire logic       mclk_in,
  input  wire logic       tx_tick_in,
  input  wire logic       rx_tick_in,
  input  wire logic       line_in,
  input  wire logic       nine_in,
  output logic            line_out,
  output logic            got_out,
  output logic [8:0]      data_out,
  output logic            stop_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int         cnt = 0;
  logic       armed = 1'b1;
  logic [9:0] sh = 10'h000;
  initial line_out = 1'b1;
  initial got_out = 1'b0;
  assign data_out = nine_in ? sh[8:0] : {1'b0, sh[8:1]};
  assign stop_out = sh[9];
  // ---------------------------------------------------------------
  // listener on the device's transmit line
  // ---------------------------------------------------------------
  // a low stop leaves us disarmed until a one is seen, as a real
  // receiver needs a rising edge before the next start
  always @(posedge mclk_in) begin
    got_out <= 1'b0;
    if (tx_tick_in) begin
      if (cnt == 0) begin
        if (!line_in && armed) cnt <= 1;
        if (line_in) armed <= 1'b1;
      end else begin
        sh <= {line_in, sh[9:1]};
        if (cnt == (nine_in ? 10 : 9)) begin
          cnt     <= 0;
          got_out <= line_in;
          armed   <= line_in;
        end else begin
          cnt <= cnt + 1;
        end
      end
    end
  end
  // ---------------------------------------------------------------
  // sender onto the device's receive line, 16 ticks per bit
  // ---------------------------------------------------------------
  task automatic send(input logic [8:0] d, input logic nine,
                      input logic stop, input int glitch);
    logic [10:0] f;
    int          n;
    f = nine ? {stop, d, 1'b0} : {1'b0, stop, d[7:0], 1'b0};
    n = nine ? 11 : 10;
    for (int b = 0; b < n; b++) begin
      for (int s = 0; s < 16; s++) begin
        @(posedge mclk_in iff rx_tick_in);
        line_out <= f[b] ^ (b == glitch && s == 8);
      end
    end
    @(posedge mclk_in iff rx_tick_in);
    line_out <= 1'b1;
  endtask : send
  // short low pulse: a start edge whose middle samples read high
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge mclk_in iff rx_tick_in);
      line_out <= 1'b0;
    end
    repeat (32) begin
      @(posedge mclk_in iff rx_tick_in);
      line_out <= 1'b1;
    end
  endtask : pulse
endmodule : asu_far_end
`default_nettype wire

//--- asu_core_test.sv
`default_nettype none
module asu_core_test
  import asu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 0, rst = 1, rd = 0, wr = 0, ttick = 0, rtick = 0;
  logic        mask = 0, txl, irq, prx, got, fstop, wreq, nine = 0;
  logic [3:0]  addr = 4'h0;
  logic [1:0]  tcn = 2'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic [8:0]  fdat;
  logic [63:0] rq[$];
  logic [31:0] txq[$];
  int          mismatches = 0, n_tests = 0;
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) begin
    tcn   <= tcn + 2'h1;
    ttick <= (tcn == 2'h3);
    rtick <= tcn[0];
  end
  asu_core uut (.mclk_in(mclk), .sys_rst_in(rst), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .tx_tick_in(ttick), .rx_tick_in(rtick),
    .serial_rx_line_in(prx), .cpu_irq_mask_in(mask),
    .serial_tx_line_out(txl), .irq_out(irq));
  asu_far_end far (.mclk_in(mclk), .tx_tick_in(ttick), .rx_tick_in(rtick),
    .line_in(txl), .nine_in(nine), .line_out(prx), .got_out(got),
    .data_out(fdat), .stop_out(fstop));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic close_out();
    $display("comparisons=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    int k;
    rd <= !w;
    wr <= w;
    addr <= a;
    wdat <= {24'h0, d};
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    if (k >= 50) begin
      mismatches++;
      close_out();
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge mclk);
  endtask : bus
  task automatic rdx(input logic [3:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    logic [31:0] q;
    rq.push_back({m, e});
    bus(1'b0, a, 8'h00, q);
  endtask : rdx
  task automatic wrx(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wrx
  // bounded poll of the status register until a bit in m is set
  task automatic wait_st(input logic [7:0] m);
    logic [31:0] q;
    int          k;
    q = 32'h0;
    for (k = 0; k < 400 && (q[7:0] & m) == 8'h00; k++) begin
      rq.push_back(64'h0);
      bus(1'b0, ADDR_STAT, 8'h00, q);
    end
    if (k >= 400) begin
      mismatches++;
      close_out();
    end
  endtask : wait_st
  task automatic drain();
    int k;
    for (k = 0; k < 3000 && txq.size() > 0; k++) @(posedge mclk);
    if (k >= 3000) begin
      mismatches++;
      close_out();
    end
  endtask : drain
  // ---------------------------------------------------------------
  // watcher: oldest note against each result
  // ---------------------------------------------------------------
  always @(posedge mclk) begin
    logic [63:0] e;
    if (rd && wreq === 1'b0) begin
      e = rq.pop_front();
      chk(rdat & e[63:32], e[31:0]);
    end
    if (got === 1'b1) chk(32'({fstop, fdat}), txq.pop_front());
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [8:0] d, d0;
    logic [7:0] ex[3];
    void'($urandom(98));
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rdx(ADDR_STAT, 32'hFF, 32'hC0);
    rdx(4'h2, 32'hFFFFFFFF, 32'h0);
    rdx(ADDR_CTL2, 32'hFF, 32'h0);
    wrx(ADDR_CTL2, 8'h80);
    @(posedge mclk);
    chk(32'(irq), 32'h1);
    $display("reset test done");
    wrx(ADDR_CTL2, 8'h0C);
    for (int m = 0; m < 2; m++) begin
      nine <= m[0];
      wrx(ADDR_CTL1, {6'h0, m[0], m[0]});
      for (int i = 0; i < 3; i++) begin
        d = 9'($urandom);
        wait_st(8'h80);
        wrx(ADDR_DATA, d[7:0]);
        txq.push_back(32'({1'b1, m[0], d[7:0]}));
        if (i == 1) rdx(ADDR_STAT, 32'h80, 32'h0);
      end
      drain();
      wait_st(8'h40);
    end
    $display("transmit test done");
    wrx(ADDR_CTL2, 8'h0D);
    repeat (60) @(posedge mclk);
    repeat (30) begin
      @(posedge mclk iff ttick);
      chk(32'(txl), 32'h0);
    end
    wrx(ADDR_CTL2, 8'h0C);
    wait_st(8'h80);
    d = 9'($urandom);
    wrx(ADDR_DATA, d[7:0]);
    txq.push_back(32'({2'b11, d[7:0]}));
    drain();
    $display("break test done");
    wrx(ADDR_CTL2, 8'h2C);
    ex = '{8'h20, 8'h22, 8'h24};
    for (int c = 0; c < 3; c++) begin
      d = 9'($urandom);
      mask <= c[0];
      far.send(d, 1'b1, c != 1, c == 2 ? 2 : -1);
      wait_st(8'h20);
      chk(32'(irq), 32'(!c[0]));
      rdx(ADDR_STAT, 32'h2E, 32'(ex[c]));
      rdx(ADDR_DATA, 32'hFF, 32'(d[7:0]));
      rdx(ADDR_CTL1, 32'h4, 32'({d[8], 2'b00}));
      rdx(ADDR_STAT, 32'h2E, 32'h0);
    end
    mask <= 1'b0;
    d = 9'($urandom);
    far.pulse(4);
    far.send(d, 1'b1, 1'b1, -1);
    wait_st(8'h20);
    rdx(ADDR_STAT, 32'h2E, 32'h24);
    rdx(ADDR_DATA, 32'hFF, 32'(d[7:0]));
    d0 = 9'($urandom);
    d = 9'($urandom);
    far.send(d0, 1'b1, 1'b1, -1);
    far.send(d, 1'b1, 1'b1, -1);
    wait_st(8'h20);
    rdx(ADDR_STAT, 32'h2E, 32'h28);
    rdx(ADDR_DATA, 32'hFF, 32'(d0[7:0]));
    rdx(ADDR_STAT, 32'h2E, 32'h0);
    $display("receive test done");
    close_out();
  end
endmodule : asu_core_test
`default_nettype wire
